// ### intc_pkg.sv
`default_nettype none
package intc_pkg;
   // Sources and levels
   localparam int          NUM_SRC      = 28;
   localparam logic [5:0]  SRC_BASE_NUM = 6'h04;
   localparam logic [5:0]  TRAP_USP_MIN = 6'h20;
   localparam logic [2:0]  LVL_DIS      = 3'h0;
   localparam logic [2:0]  LVL_TOP      = 3'h7;
   localparam int          CTRL_PEND    = 3;
   // Special sources, index 0 wins
   localparam int          SPC_N        = 7;
   localparam int          SPC_DEBUG    = 0;
   localparam int          SPC_NMI      = 1;
   localparam int          SPC_WDOG     = 2;
   localparam int          SPC_OSC      = 3;
   localparam int          SPC_LVD      = 4;
   localparam int          SPC_AMATCH   = 5;
   localparam int          SPC_STEP     = 6;
   localparam logic [6:0]  SPC_IPL_TOP  = 7'h1E;
   // Fixed vector addresses
   localparam logic [19:0] VEC_AMATCH   = 20'hFFFE8;
   localparam logic [19:0] VEC_STEP     = 20'hFFFEC;
   localparam logic [19:0] VEC_WDOG     = 20'hFFFF0;
   localparam logic [19:0] VEC_DEBUG    = 20'hFFFF4;
   localparam logic [19:0] VEC_NMI      = 20'hFFFF8;
   localparam logic [19:0] INFO_ADDR    = 20'h00000;
   // Status word fields
   localparam int          PSW_D        = 1;
   localparam int          PSW_I        = 6;
   localparam int          PSW_U        = 7;
   localparam int          PSW_IPL_LO   = 12;
   localparam int          PSW_IPL_HI   = 14;
   localparam logic [15:0] PSW_RST      = 16'h0000;
   localparam logic [19:0] SP_RST       = 20'h00000;
   localparam logic [19:0] VECTOR_TABLE_BASE_RST     = 20'h00000;
   // Register offsets
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   localparam logic [11:0] OFF_PSW      = 12'h080;
   localparam logic [11:0] OFF_ISP      = 12'h084;
   localparam logic [11:0] OFF_USP      = 12'h088;
   localparam logic [11:0] OFF_VECTOR_TABLE_BASE     = 12'h08C;
   localparam logic [11:0] OFF_STATUS   = 12'h090;
   localparam logic [11:0] OFF_INFO     = 12'h094;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
   // Entry and return sequencer
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_INFO   = 4'b0001,
      ST_PUSH_F = 4'b0010,
      ST_PUSH_P = 4'b0011,
      ST_VEC_L  = 4'b0100,
      ST_VEC_H  = 4'b0101,
      ST_POP_P  = 4'b0110,
      ST_POP_F  = 4'b0111
   } seq_state_t;
   typedef enum logic [1:0] {
      KIND_MASK = 2'b00,
      KIND_TRAP = 2'b01,
      KIND_SPC  = 2'b10
   } src_kind_t;
endpackage
`default_nettype wire

// ### maskable_interrupt_priority_control.sv
`timescale 1ns/1ps
`default_nettype none
module maskable_interrupt_priority_control
   import intc_pkg::*;
(
   // Clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // Interrupt sources
   input  wire logic [NUM_SRC-1:0] src_req,
   input  wire logic [SPC_N-1:0]   special_req,
   input  wire logic               trap_req,
   input  wire logic [5:0]         trap_num,
   // CPU core
   input  wire logic               insn_done,
   input  wire logic               insn_suspendable,
   input  wire logic               return_from_trap_op_req,
   input  wire logic [19:0]        cpu_pc,
   output logic                    seq_busy,
   output logic                    pc_load,
   output logic      [19:0]        pc_new,
   output logic      [15:0]        psw_out,
   // Sequence memory port
   output logic                    mem_req,
   output logic      [19:0]        mem_addr,
   output logic                    mem_wr,
   output logic                    mem_byte,
   output logic      [15:0]        mem_wdata,
   input  wire logic               mem_ack,
   input  wire logic [15:0]        mem_rdata
);
   logic [NUM_SRC-1:0] pend_reg;
   logic [2:0]         prio_reg [0:NUM_SRC-1];
   logic [15:0]        psw_reg;
   logic [19:0]        isp_reg;
   logic [19:0]        usp_reg;
   logic [19:0]        vector_table_base_reg;
   seq_state_t         state_reg;
   seq_state_t         state_next;
   src_kind_t          kind_reg;
   logic [5:0]         num_reg;
   logic [2:0]         lvl_reg;
   logic [2:0]         spc_idx_reg;
   logic [15:0]        tmp_flg_reg;
   logic [19:0]        pc_reg;
   logic [19:0]        sp_reg;
   logic               usp_sel_reg;
   logic [19:0]        vec_base_reg;
   logic               half_reg;
   logic               half_next;
   logic [15:0]        word_reg;
   logic [15:0]        info_reg;
   logic               wr_act_reg;
   logic [11:0]        wr_off_reg;
   // Bus address phase
   logic        ahb_go;
   logic [11:0] ahb_off;
   logic [31:0] rd_val;
   assign ahb_go  = hsel && hready && (htrans == HTRANS_NSEQ);
   assign ahb_off = haddr[11:0];

   // Priority chain over maskable sources
   logic [2:0] chain_lvl [0:NUM_SRC];
   logic [4:0] chain_idx [0:NUM_SRC];
   assign chain_lvl[0] = LVL_DIS;
   assign chain_idx[0] = 5'h00;
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : gen_src
         logic take;
         logic ctrl_wr;
         assign take    = pend_reg[g] && (prio_reg[g] > chain_lvl[g]);
         assign chain_lvl[g+1] = take ? prio_reg[g] : chain_lvl[g];
         assign chain_idx[g+1] = take ? 5'(g) : chain_idx[g];
         assign ctrl_wr = wr_act_reg && (wr_off_reg == OFF_CTRL + 12'(g * 4));
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pend_reg[g] <= 1'b0;
            end else if (src_req[g]) begin
               pend_reg[g] <= 1'b1;
            end else if (state_reg == ST_INFO && mem_ack && kind_reg == KIND_MASK &&
                         num_reg == SRC_BASE_NUM + 6'(g)) begin
               pend_reg[g] <= 1'b0;
            end else if (ctrl_wr && !hwdata[CTRL_PEND]) begin
               pend_reg[g] <= 1'b0;
            end
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               prio_reg[g] <= LVL_DIS;
            end else if (ctrl_wr) begin
               prio_reg[g] <= hwdata[2:0];
            end
         end
      end
   endgenerate

   // Acceptance decision
   logic [2:0] best_lvl;
   logic [4:0] best_idx;
   logic       sample;
   logic       mask_ok;
   logic       spc_any;
   logic [2:0] spc_pick;
   logic       acc_return_from_trap_op;
   logic       acc_spc;
   logic       acc_trap;
   logic       acc_mask;
   logic       accept;
   assign best_lvl = chain_lvl[NUM_SRC];
   assign best_idx = chain_idx[NUM_SRC];
   assign sample   = (state_reg == ST_IDLE) && (insn_done || insn_suspendable);
   assign mask_ok  = psw_reg[PSW_I] && (best_lvl > psw_reg[PSW_IPL_HI:PSW_IPL_LO]);
   assign spc_any  = |special_req;
   always_comb begin
      spc_pick = 3'h0;
      for (int k = SPC_N - 1; k >= 0; k--) begin
         if (special_req[k]) begin
            spc_pick = 3'(k);
         end
      end
   end
   assign acc_return_from_trap_op = sample && return_from_trap_op_req;
   assign acc_spc  = sample && !return_from_trap_op_req && spc_any;
   assign acc_trap = sample && !return_from_trap_op_req && !spc_any && trap_req;
   assign acc_mask = sample && !return_from_trap_op_req && !spc_any && !trap_req && mask_ok;
   assign accept   = acc_spc || acc_trap || acc_mask;

   // Stack pointer for the sequence
   logic        high_trap;
   logic        use_usp;
   logic [19:0] sp_cur;
   logic [19:0] sp_use;
   assign high_trap = acc_trap && (trap_num >= TRAP_USP_MIN);
   assign use_usp   = (high_trap || acc_return_from_trap_op) && psw_reg[PSW_U];
   assign sp_cur    = use_usp ? usp_reg : isp_reg;
   assign sp_use    = (state_reg == ST_IDLE) ? sp_cur : sp_reg;

   // Sequencer
   logic last_part;
   assign last_part = !sp_reg[0] || half_reg ||
                      state_reg == ST_INFO || state_reg == ST_VEC_L || state_reg == ST_VEC_H;
   always_comb begin
      state_next = state_reg;
      half_next  = half_reg;
      if (state_reg == ST_IDLE) begin
         if (acc_return_from_trap_op) begin
            state_next = ST_POP_P;
         end else if (accept) begin
            state_next = ST_INFO;
         end
      end else if (mem_ack) begin
         if (!last_part) begin
            half_next = 1'b1;
         end else begin
            half_next = 1'b0;
            case (state_reg)
               ST_INFO:   state_next = ST_PUSH_F;
               ST_PUSH_F: state_next = ST_PUSH_P;
               ST_PUSH_P: state_next = ST_VEC_L;
               ST_VEC_L:  state_next = ST_VEC_H;
               ST_POP_P:  state_next = ST_POP_F;
               default:   state_next = ST_IDLE;
            endcase
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         half_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         half_reg  <= half_next;
      end
   end

   // Captured context at acceptance
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         kind_reg     <= KIND_MASK;
         num_reg      <= 6'h00;
         lvl_reg      <= LVL_DIS;
         spc_idx_reg  <= 3'h0;
         tmp_flg_reg  <= PSW_RST;
         pc_reg       <= 20'h00000;
         sp_reg       <= SP_RST;
         usp_sel_reg  <= 1'b0;
         vec_base_reg <= VECTOR_TABLE_BASE_RST;
      end else if (state_reg == ST_IDLE && (accept || acc_return_from_trap_op)) begin
         kind_reg     <= acc_spc ? KIND_SPC : (acc_trap ? KIND_TRAP : KIND_MASK);
         num_reg      <= acc_trap ? trap_num : SRC_BASE_NUM + 6'(best_idx);
         lvl_reg      <= best_lvl;
         spc_idx_reg  <= spc_pick;
         tmp_flg_reg  <= psw_reg;
         pc_reg       <= cpu_pc;
         sp_reg       <= sp_cur;
         usp_sel_reg  <= use_usp;
         vec_base_reg <= vector_table_base_reg + {12'h000, (acc_trap ? trap_num : SRC_BASE_NUM + 6'(best_idx)), 2'h0};
      end
   end

   // Fixed vectors for special sources
   logic [19:0] vec_addr;
   always_comb begin
      case (spc_idx_reg)
         3'(SPC_DEBUG):  vec_addr = VEC_DEBUG;
         3'(SPC_NMI):    vec_addr = VEC_NMI;
         3'(SPC_AMATCH): vec_addr = VEC_AMATCH;
         3'(SPC_STEP):   vec_addr = VEC_STEP;
         default:        vec_addr = VEC_WDOG;
      endcase
      if (kind_reg != KIND_SPC) begin
         vec_addr = vec_base_reg;
      end
   end

   // Memory port driven for the next state
   logic [15:0] flg_word;
   logic [19:0] acc_addr;
   logic [15:0] acc_data;
   logic        acc_wr;
   assign flg_word = {tmp_flg_reg[15:12], pc_reg[19:16], tmp_flg_reg[7:0]};
   always_comb begin
      acc_wr   = 1'b0;
      acc_data = 16'h0000;
      case (state_next)
         ST_INFO:   acc_addr = INFO_ADDR;
         ST_PUSH_F: begin
            acc_addr = sp_use - 20'h00002;
            acc_data = flg_word;
            acc_wr   = 1'b1;
         end
         ST_PUSH_P: begin
            acc_addr = sp_use - 20'h00004;
            acc_data = pc_reg[15:0];
            acc_wr   = 1'b1;
         end
         ST_VEC_L:  acc_addr = vec_addr;
         ST_VEC_H:  acc_addr = vec_addr + 20'h00002;
         ST_POP_P:  acc_addr = sp_use;
         ST_POP_F:  acc_addr = sp_use + 20'h00002;
         default:   acc_addr = INFO_ADDR;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_req   <= 1'b0;
         mem_addr  <= INFO_ADDR;
         mem_wr    <= 1'b0;
         mem_byte  <= 1'b0;
         mem_wdata <= 16'h0000;
      end else begin
         mem_req   <= (state_next != ST_IDLE);
         mem_wr    <= acc_wr;
         mem_byte  <= sp_use[0] && (state_next == ST_PUSH_F || state_next == ST_PUSH_P ||
                      state_next == ST_POP_P || state_next == ST_POP_F);
         mem_addr  <= acc_addr + {19'h00000, half_next};
         mem_wdata <= (sp_use[0] && half_next) ? {8'h00, acc_data[15:8]} :
                      (sp_use[0] ? {8'h00, acc_data[7:0]} : acc_data);
      end
   end

   // Read data assembly and PC load
   logic [15:0] rd_word;
   logic [7:0]  byte_reg;
   assign rd_word = !sp_reg[0] || state_reg == ST_VEC_L || state_reg == ST_VEC_H ? mem_rdata :
                    (half_reg ? {mem_rdata[7:0], byte_reg} : {8'h00, mem_rdata[7:0]});
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         word_reg <= 16'h0000;
         byte_reg <= 8'h00;
         info_reg <= 16'h0000;
         pc_load  <= 1'b0;
         pc_new   <= 20'h00000;
      end else begin
         pc_load <= 1'b0;
         if (mem_ack && state_reg != ST_IDLE) begin
            byte_reg <= mem_rdata[7:0];
            if (last_part) begin
               word_reg <= rd_word;
            end
            if (state_reg == ST_INFO) begin
               info_reg <= mem_rdata;
            end
            if (state_reg == ST_VEC_H) begin
               pc_new  <= {rd_word[3:0], word_reg};
               pc_load <= 1'b1;
            end
            if (state_reg == ST_POP_F && last_part) begin
               pc_new  <= {rd_word[11:8], word_reg};
               pc_load <= 1'b1;
            end
         end
      end
   end

   // Status word and stack pointers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psw_reg <= PSW_RST;
      end else if (state_reg == ST_INFO && mem_ack) begin
         psw_reg[PSW_I] <= 1'b0;
         psw_reg[PSW_D] <= 1'b0;
         if (!(kind_reg == KIND_TRAP && num_reg >= TRAP_USP_MIN)) begin
            psw_reg[PSW_U] <= 1'b0;
         end
      end else if (state_reg == ST_PUSH_P && mem_ack && last_part) begin
         if (kind_reg == KIND_MASK) begin
            psw_reg[PSW_IPL_HI:PSW_IPL_LO] <= lvl_reg;
         end else if (kind_reg == KIND_SPC && SPC_IPL_TOP[spc_idx_reg]) begin
            psw_reg[PSW_IPL_HI:PSW_IPL_LO] <= LVL_TOP;
         end
      end else if (state_reg == ST_POP_F && mem_ack && last_part) begin
         psw_reg <= {rd_word[15:12], 4'h0, rd_word[7:0]};
      end else if (wr_act_reg && wr_off_reg == OFF_PSW) begin
         psw_reg <= hwdata[15:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         isp_reg <= SP_RST;
         usp_reg <= SP_RST;
      end else if ((state_reg == ST_PUSH_P || state_reg == ST_POP_F) && mem_ack && last_part) begin
         if (usp_sel_reg) begin
            usp_reg <= (state_reg == ST_PUSH_P) ? sp_reg - 20'h00004 : sp_reg + 20'h00004;
         end else begin
            isp_reg <= (state_reg == ST_PUSH_P) ? sp_reg - 20'h00004 : sp_reg + 20'h00004;
         end
      end else if (wr_act_reg && wr_off_reg == OFF_ISP) begin
         isp_reg <= hwdata[19:0];
      end else if (wr_act_reg && wr_off_reg == OFF_USP) begin
         usp_reg <= hwdata[19:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_table_base_reg <= VECTOR_TABLE_BASE_RST;
      end else if (wr_act_reg && wr_off_reg == OFF_VECTOR_TABLE_BASE) begin
         vector_table_base_reg <= hwdata[19:0];
      end
   end

   // AHB-Lite slave, zero wait
   always_comb begin
      rd_val = 32'h00000000;
      case (ahb_off)
         OFF_PSW:    rd_val = {16'h0000, psw_reg};
         OFF_ISP:    rd_val = {12'h000, isp_reg};
         OFF_USP:    rd_val = {12'h000, usp_reg};
         OFF_VECTOR_TABLE_BASE:   rd_val = {12'h000, vector_table_base_reg};
         OFF_STATUS: rd_val = {20'h00000, kind_reg, num_reg, state_reg};
         OFF_INFO:   rd_val = {16'h0000, info_reg};
         default: begin
            if (ahb_off < OFF_CTRL + 12'(NUM_SRC * 4)) begin
               rd_val = {28'h0000000, pend_reg[ahb_off[6:2]], prio_reg[ahb_off[6:2]]};
            end
         end
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_act_reg <= 1'b0;
         wr_off_reg <= 12'h000;
         hrdata     <= 32'h00000000;
         hreadyout  <= 1'b0;
         hresp      <= 1'b0;
      end else begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         wr_act_reg <= ahb_go && hwrite;
         wr_off_reg <= ahb_off;
         if (ahb_go && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_busy <= 1'b0;
         psw_out  <= PSW_RST;
      end else begin
         seq_busy <= (state_next != ST_IDLE);
         psw_out  <= psw_reg;
      end
   end

   // Checks
   a_mask_enable: assert property (@(posedge hclk) disable iff (!hresetn)
      acc_mask |-> psw_reg[PSW_I]) else $error("maskable accepted with enable clear");
   a_level_above: assert property (@(posedge hclk) disable iff (!hresetn)
      acc_mask |-> best_lvl > psw_reg[PSW_IPL_HI:PSW_IPL_LO] && best_lvl != LVL_DIS)
      else $error("maskable level not above PROCESSOR_PRIORITY_LEVEL");
   a_info_first: assert property (@(posedge hclk) disable iff (!hresetn)
      accept |=> mem_req && !mem_wr && mem_addr == INFO_ADDR && seq_busy)
      else $error("sequence did not start with info read");
   a_pend_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_INFO && mem_ack && kind_reg == KIND_MASK && !src_req[5'(num_reg - SRC_BASE_NUM)]
      |=> !pend_reg[5'(num_reg - SRC_BASE_NUM)]) else $error("pending bit not cleared");
   a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
      src_req[0] |=> pend_reg[0]) else $error("request lost");
   a_flags_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_INFO && mem_ack |=> !psw_reg[PSW_I] && !psw_reg[PSW_D])
      else $error("flags not cleared");
   a_ipl_load: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_PUSH_P && mem_ack && last_part && kind_reg == KIND_MASK
      |=> psw_reg[PSW_IPL_HI:PSW_IPL_LO] == lvl_reg ##1 state_reg == ST_VEC_L)
      else $error("PROCESSOR_PRIORITY_LEVEL not loaded");
   a_ipl_top: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == ST_PUSH_P && mem_ack && last_part && kind_reg == KIND_SPC && SPC_IPL_TOP[spc_idx_reg]
      |=> psw_reg[PSW_IPL_HI:PSW_IPL_LO] == LVL_TOP) else $error("PROCESSOR_PRIORITY_LEVEL not raised to top");
   a_byte_odd: assert property (@(posedge hclk) disable iff (!hresetn)
      mem_req && mem_wr |-> mem_byte == sp_reg[0]) else $error("stack width wrong");
   a_trap_go: assert property (@(posedge hclk) disable iff (!hresetn)
      acc_trap |=> state_reg == ST_INFO && kind_reg == KIND_TRAP) else $error("trap not taken");
   a_tie_low: assert property (@(posedge hclk) disable iff (!hresetn)
      pend_reg[0] && prio_reg[0] != LVL_DIS && prio_reg[0] == best_lvl |-> best_idx == 5'h00)
      else $error("tie not to lowest source");
endmodule
`default_nettype wire

// ### cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   // Clock, reset and sequence memory port
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        mem_req,
   input  wire logic [19:0] mem_addr,
   input  wire logic        mem_wr,
   input  wire logic        mem_byte,
   input  wire logic [15:0] mem_wdata,
   output logic             mem_ack,
   output logic      [15:0] mem_rdata
);
   logic [3:0]  cnt;
   logic [37:0] log_q[$];
   // Stack memory; other reads echo the address
   logic [7:0]  ram [0:2047];
   logic        in_ram;
   logic [10:0] a_lo;
   logic [10:0] a_hi;
   assign in_ram = (mem_addr[19:11] == 9'h000) && (mem_addr[10:9] != 2'h0);
   assign a_lo   = mem_addr[10:0];
   assign a_hi   = mem_addr[10:0] + 11'h001;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt       <= 4'h0;
         mem_ack   <= 1'h0;
         mem_rdata <= 16'hA5A5;
      end else if (mem_req && !mem_ack && cnt == {2'h0, mem_addr[2:1]}) begin
         mem_ack   <= 1'h1;
         if (mem_wr) begin
            ram[a_lo] <= mem_wdata[7:0];
            if (!mem_byte) begin
               ram[a_hi] <= mem_wdata[15:8];
            end
            mem_rdata <= ~mem_rdata;
         end else begin
            mem_rdata <= in_ram ? {ram[a_hi], ram[a_lo]} : mem_addr[15:0];
         end
         log_q.push_back({mem_wr, mem_byte, mem_addr, mem_wdata});
      end else begin
         mem_ack   <= 1'h0;
         mem_rdata <= ~mem_rdata;
         cnt       <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ### maskable_interrupt_priority_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module maskable_interrupt_priority_control_tb_top
   import intc_pkg::*;
;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, trap_req = 1'h0, mem_byte, mem_ack;
   logic insn_done = 1'h0, insn_suspendable = 1'h0, hreadyout, hresp, seq_busy, pc_load, mem_req, mem_wr;
   logic               return_from_trap_op_req = 1'h0;
   logic [1:0]         htrans = 2'h0;
   logic [5:0]         trap_num = 6'h28;
   logic [15:0]        psw_out, mem_wdata, mem_rdata;
   logic [19:0]        cpu_pc = 20'hABCDE, sp = 20'h00400, pc_new, mem_addr;
   logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [NUM_SRC-1:0] src_req = 28'h0;
   logic [SPC_N-1:0]   special_req = 7'h0;
   int                 fails = 0, comparisons = 0;
   maskable_interrupt_priority_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_req, .special_req, .trap_req, .trap_num,
      .insn_done, .insn_suspendable, .return_from_trap_op_req, .cpu_pc, .seq_busy, .pc_load, .pc_new, .psw_out,
      .mem_req, .mem_addr, .mem_wr, .mem_byte, .mem_wdata, .mem_ack, .mem_rdata);
   cpu_core_model u_cpu (.hclk, .hresetn, .mem_req, .mem_addr, .mem_wr, .mem_byte, .mem_wdata, .mem_ack,
      .mem_rdata);
   always #10 hclk = ~hclk;
   initial begin
      repeat (5000) @(posedge hclk);
      fails++;
      end_of_test();
   end
   task automatic end_of_test();
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, e);
      comparisons++;
      fails += (g !== e);
      if (g !== e) $display("wrong value at %0t: %h expected %h", $time, g, e);
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {20'h0, a};
      htrans <= HTRANS_NSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      chk(hresp, 1'h0);
      if (!w) chk(hrdata, d);
   endtask
   task automatic quiet();
      insn_done <= 1'h1;
      @(posedge hclk);
      insn_done <= 1'h0;
      repeat (3) @(negedge hclk);
      chk(seq_busy, 1'h0);
      @(posedge hclk);
   endtask
   task automatic take(input logic [1:0] m, input logic [19:0] va, input logic [15:0] fw, pw);
      insn_done <= (m != 2'h1);
      insn_suspendable <= (m == 2'h1);
      trap_req <= (m == 2'h2);
      special_req <= {5'h0, m == 2'h3, 1'h0};
      @(posedge hclk);
      insn_done <= 1'h0;
      insn_suspendable <= 1'h0;
      trap_req <= 1'h0;
      special_req <= 7'h0;
      repeat (80) if (pc_load !== 1'h1) @(negedge hclk);
      chk(pc_load, 1'h1);
      chk(pc_new, {va[3:0] + 4'h2, va[15:0]});
      chk(psw_out, pw);
      chk(u_cpu.log_q[0][35:16], INFO_ADDR);
      if (sp[0]) begin
         chk(u_cpu.log_q[1], {2'h3, sp - 20'h2, 8'h00, fw[7:0]});
         chk(u_cpu.log_q[2], {2'h3, sp - 20'h1, 8'h00, fw[15:8]});
         chk(u_cpu.log_q[3], {2'h3, sp - 20'h4, 8'h00, cpu_pc[7:0]});
         chk(u_cpu.log_q[4], {2'h3, sp - 20'h3, 8'h00, cpu_pc[15:8]});
      end else begin
         chk(u_cpu.log_q[1], {2'h2, sp - 20'h2, fw});
         chk(u_cpu.log_q[2], {2'h2, sp - 20'h4, cpu_pc[15:0]});
      end
      u_cpu.log_q.delete();
      sp = sp - 20'h4;
      @(posedge hclk);
   endtask
   task automatic ret(input logic [19:0] pc, input logic [15:0] pw);
      insn_done <= 1'h1;
      return_from_trap_op_req <= 1'h1;
      @(posedge hclk);
      insn_done <= 1'h0;
      return_from_trap_op_req <= 1'h0;
      repeat (80) if (pc_load !== 1'h1) @(negedge hclk);
      chk(pc_load, 1'h1);
      chk(pc_new, pc);
      @(negedge hclk);
      chk(psw_out, pw);
      u_cpu.log_q.delete();
      sp = sp + 20'h4;
      @(posedge hclk);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (2) @(posedge hclk);
      bus(1'h0, 12'h200, 32'h0);
      bus(1'h1, OFF_ISP, 32'h400);
      bus(1'h1, OFF_VECTOR_TABLE_BASE, 32'h1000);
      bus(1'h1, OFF_PSW, 32'h2040);
      for (int g = 0; g < 4; g++) bus(1'h1, 12'(4 * g), (g < 2) ? 32'h3 : (g == 2) ? 32'h2 : 32'h0);
      src_req <= 28'hF;
      @(posedge hclk);
      src_req <= 28'h0;
      take(2'h0, 20'h01010, 16'h2A40, 16'h3000);
      bus(1'h0, OFF_CTRL, 32'h3);
      bus(1'h1, OFF_PSW, 32'h0);
      quiet();
      bus(1'h1, OFF_PSW, 32'h7040);
      quiet();
      bus(1'h1, 12'h004, 32'h7);
      bus(1'h0, 12'h004, 32'h7);
      bus(1'h1, OFF_PSW, 32'h0040);
      take(2'h1, 20'h01018, 16'h0A40, 16'h2000);
      bus(1'h0, 12'h00C, 32'h8);
      take(2'h2, 20'h010A0, 16'h2A00, 16'h2000);
      take(2'h3, VEC_NMI, 16'h2A00, 16'h7000);
      ret(20'hABCDE, 16'h2000);
      bus(1'h0, OFF_ISP, 32'h3F4);
      bus(1'h1, OFF_ISP, 32'h3F3);
      cpu_pc <= 20'h54321;
      sp = 20'h003F3;
      take(2'h2, 20'h010A0, 16'h2500, 16'h2000);
      ret(20'h54321, 16'h2000);
      bus(1'h1, OFF_USP, 32'h300);
      bus(1'h1, OFF_PSW, 32'h0080);
      sp = 20'h00300;
      take(2'h2, 20'h010A0, 16'h0580, 16'h0080);
      ret(20'h54321, 16'h0080);
      bus(1'h0, OFF_USP, 32'h300);
      bus(1'h0, OFF_ISP, 32'h3F3);
      end_of_test();
   end
endmodule
`default_nettype wire
